// >>> verilog/tsp_pkg.sv
// Shared constants for the transport stream parser.
// Assumes a single 100 MHz system clock domain.
package tsp_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int BURST_KBPS = 72800;
  localparam int BYTE_NS = (8000000 + BURST_KBPS - 1) / BURST_KBPS;
  localparam int BYTE_GAP_CYC = (BYTE_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------------------------------
  // Packet layout
  // ----------------------------------------------------------------
  localparam int PKT_LEN = 188;
  localparam int HDR_LEN = 4;
  localparam int IDX_ALEN = 4;
  localparam int IDX_PCR = 5;
  localparam int BIT_ADAPT = 5;
  localparam int BIT_PAYLOAD = 4;
  localparam int BIT_PCR = 4;
  localparam int PID_W = 13;
  localparam int CC_W = 4;
  localparam int KEY_W = 64;
  localparam int STC_W = 42;
  // ----------------------------------------------------------------
  // Link word layout after sampling
  // ----------------------------------------------------------------
  localparam int LNK_W = 11;
  localparam int LNK_CLK = 10;
  localparam int LNK_VAL = 9;
  localparam int LNK_SOP = 8;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CLS_DISCARD = 2'h0,
    CLS_HOST = 2'h1,
    CLS_DATA = 2'h2
  } tsp_class_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_HDR = 2'h1,
    ST_BODY = 2'h2
  } tsp_state_t;
endpackage

// >>> verilog/tsp_byte_if.sv
// Byte strobe carrier between the link sampler and the parser core.
// Assumes both ends run on sys_clk.
`timescale 1ns/10ps
interface tsp_byte_if;
  logic stb;
  logic sop;
  logic [7:0] data;
  modport src (output stb, output sop, output data);
  modport snk (input stb, input sop, input data);
endinterface

// >>> verilog/tsp_link_rx.sv
// Link sampler: three-stage capture of the stream pins, byte strobes.
// Assumes data stays stable for four sys_clk cycles after each rise.
`timescale 1ns/10ps
module tsp_link_rx (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ts_clk,
  input wire logic ts_valid,
  input wire logic ts_start,
  input wire logic [7:0] ts_data,
  tsp_byte_if.src bo
);
  typedef struct packed {
    logic [tsp_pkg::LNK_W-1:0] s1;
    logic [tsp_pkg::LNK_W-1:0] s2;
    logic [tsp_pkg::LNK_W-1:0] s3;
    logic lvl;
    logic stb;
    logic sop;
    logic [7:0] data;
  } tsp_rx_st_t;

  tsp_rx_st_t s_r, s_nxt;

  // ----------------------------------------------------------------
  // Edge finding
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = {ts_clk, ts_valid, ts_start, ts_data};
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.stb = 1'b0;
    if (s_r.s2[tsp_pkg::LNK_CLK] == s_r.s3[tsp_pkg::LNK_CLK] &&
        s_r.s3[tsp_pkg::LNK_CLK] != s_r.lvl) begin
      s_nxt.lvl = s_r.s3[tsp_pkg::LNK_CLK];
      if (s_r.s3[tsp_pkg::LNK_CLK] && s_r.s3[tsp_pkg::LNK_VAL]) begin
        s_nxt.stb = 1'b1;
        s_nxt.sop = s_r.s3[tsp_pkg::LNK_SOP];
        s_nxt.data = s_r.s3[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bo.stb = s_r.stb;
  assign bo.sop = s_r.sop;
  assign bo.data = s_r.data;

  a_stb_single: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_r.stb |=> !s_r.stb) else $error("byte strobe longer than a cycle");
endmodule

// >>> verilog/tsp_sd_dac.sv
// First-order sigma-delta modulator for the oscillator control level.
// Assumes the level is held steady by the host between updates.
`timescale 1ns/10ps
module tsp_sd_dac #(
  parameter int DIV = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] level,
  output logic dac_out
);
  localparam int DW = $clog2(DIV + 1);

  typedef struct packed {
    logic [DW-1:0] cnt;
    logic [7:0] acc;
    logic out;
  } tsp_dac_st_t;

  tsp_dac_st_t s_r, s_nxt;
  logic [8:0] sum;

  initial begin
    if (DIV < 1) $error("DIV must be at least 1");
  end

  // ----------------------------------------------------------------
  // Modulator
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    sum = {1'b0, s_r.acc} + {1'b0, level};
    if (s_r.cnt == '0) begin
      s_nxt.cnt = DW'(DIV - 1);
      s_nxt.acc = sum[7:0];
      s_nxt.out = sum[8];
    end else begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dac_out = s_r.out;

  a_dac_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_r.cnt == '0 && level == 8'h00 && s_r.acc == 8'h00 |=> !s_r.out)
    else $error("zero level produced a pulse");
endmodule

// >>> verilog/tsp_parser.sv
// Transport packet parser core: classify, forward, time-stamp, check.
// Assumes the host loads the slot and key tables before traffic starts.
//
// Behaviour
// - Accept bytes at bursts to 72.8 Mbit/s, 60 Mbit/s average per packet.
// - Classify each packet by identifier: discard, host processing, plain data.
// - Forward every packet that is not discarded toward data RAM.
// - Switch descrambling per packet from slot setting and scrambling bits.
// - Hold keys in a local table; host loads and manages them.
// - Move packet bytes outward as DMA strobes, no processor copies.
// - Raise the interrupt once a kept packet's transfer has finished.
// - Tag each stored packet as host class or pure data class.
// - Mark header bytes so the traffic side can drop them and repack.
// - Latch the system clock at arrival of any packet carrying a PCR.
// - Provide an 8-bit sigma-delta output for the external oscillator.
// - Detect lost packets and report each loss.
// - Interrupt is a fast request held until the host acknowledges.
`timescale 1ns/10ps
module tsp_parser #(
  parameter int SLOTS = 8,
  parameter int DAC_DIV = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ts_clk,
  input wire logic ts_valid,
  input wire logic ts_start,
  input wire logic [7:0] ts_data,
  input wire logic tbl_wr,
  input wire logic [$clog2(SLOTS)-1:0] tbl_idx,
  input wire logic [tsp_pkg::PID_W-1:0] tbl_pid,
  input wire logic [1:0] tbl_class,
  input wire logic tbl_descr,
  input wire logic key_wr,
  input wire logic [$clog2(SLOTS)-1:0] key_idx,
  input wire logic [tsp_pkg::KEY_W-1:0] key_data,
  input wire logic fiq_ack,
  input wire logic [7:0] dac_level,
  output logic dma_valid,
  output logic [7:0] dma_data,
  output logic dma_sop,
  output logic dma_eop,
  output logic dma_hdr,
  output logic [1:0] dma_class,
  output logic descr_en,
  output logic [tsp_pkg::KEY_W-1:0] descr_key,
  output logic fast_irq_req,
  output logic [tsp_pkg::STC_W-1:0] pcr_stamp,
  output logic pcr_valid,
  output logic lost,
  output logic [tsp_pkg::PID_W-1:0] lost_pid,
  output logic dac_out
);
  localparam int SW = $clog2(SLOTS);
  localparam int PW = tsp_pkg::PID_W;
  localparam int CW = tsp_pkg::CC_W;

  typedef struct packed {
    tsp_pkg::tsp_state_t st;
    logic [7:0] idx;
    logic [tsp_pkg::HDR_LEN-1:0][7:0] hdr;
    logic [2:0] rp;
    logic [SW-1:0] slot;
    tsp_pkg::tsp_class_t cls;
    logic pcr_arm;
    logic [tsp_pkg::STC_W-1:0] stc;
    logic [tsp_pkg::STC_W-1:0] arr;
    logic [SLOTS-1:0][PW-1:0] pid;
    logic [SLOTS-1:0][1:0] tcls;
    logic [SLOTS-1:0] tdsc;
    logic [SLOTS-1:0][CW-1:0] cc;
    logic [SLOTS-1:0] ccv;
    logic [SLOTS-1:0][tsp_pkg::KEY_W-1:0] key;
    logic dma_valid;
    logic [7:0] dma_data;
    logic dma_sop;
    logic dma_eop;
    logic dma_hdr;
    logic descr_en;
    logic [tsp_pkg::KEY_W-1:0] descr_key;
    logic irq;
    logic [tsp_pkg::STC_W-1:0] pcr_stamp;
    logic pcr_valid;
    logic lost;
    logic [PW-1:0] lost_pid;
  } tsp_par_st_t;

  tsp_par_st_t s_r, s_nxt;
  tsp_byte_if bs ();

  initial begin
    if (SLOTS < 2 || (1 << SW) != SLOTS) $error("SLOTS: power of two >= 2");
    if (tsp_pkg::HDR_LEN >= tsp_pkg::BYTE_GAP_CYC) $error("header replay");
  end

  // ----------------------------------------------------------------
  // Slot lookup
  // ----------------------------------------------------------------
  function automatic logic [SW:0] f_match(
    input logic [PW-1:0] p,
    input logic [SLOTS-1:0][PW-1:0] t,
    input logic [SLOTS-1:0][1:0] c
  );
    logic [SW:0] r;
    r = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (t[i] == p && c[i] != 2'(tsp_pkg::CLS_DISCARD)) begin
        r = {1'b1, SW'(i)};
      end
    end
    return r;
  endfunction

  tsp_link_rx u_rx (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ts_clk(ts_clk),
    .ts_valid(ts_valid),
    .ts_start(ts_start),
    .ts_data(ts_data),
    .bo(bs.src)
  );

  tsp_sd_dac #(.DIV(DAC_DIV)) u_dac (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .level(dac_level),
    .dac_out(dac_out)
  );

  // ----------------------------------------------------------------
  // Packet engine
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] ri;
    logic [PW-1:0] p;
    logic [SW:0] m;
    logic [CW-1:0] cn;
    logic [CW-1:0] cl;
    ri = 2'(3'(tsp_pkg::HDR_LEN) - s_r.rp);
    p = {s_r.hdr[1][4:0], s_r.hdr[2]};
    m = f_match(p, s_r.pid, s_r.tcls);
    cn = bs.data[CW-1:0];
    cl = s_r.cc[m[SW-1:0]];
    s_nxt = s_r;
    s_nxt.dma_valid = 1'b0;
    s_nxt.dma_sop = 1'b0;
    s_nxt.dma_eop = 1'b0;
    s_nxt.dma_hdr = 1'b0;
    s_nxt.pcr_valid = 1'b0;
    s_nxt.lost = 1'b0;
    s_nxt.stc = s_r.stc + 1'b1;
    if (fiq_ack) begin
      s_nxt.irq = 1'b0;
    end
    if (tbl_wr) begin
      s_nxt.pid[tbl_idx] = tbl_pid;
      s_nxt.tcls[tbl_idx] = tbl_class;
      s_nxt.tdsc[tbl_idx] = tbl_descr;
      s_nxt.ccv[tbl_idx] = 1'b0;
    end
    if (key_wr) begin
      s_nxt.key[key_idx] = key_data;
    end
    if (s_r.rp != 3'h0) begin
      s_nxt.dma_valid = 1'b1;
      s_nxt.dma_data = s_r.hdr[ri];
      s_nxt.dma_sop = s_r.rp == 3'(tsp_pkg::HDR_LEN);
      s_nxt.dma_hdr = 1'b1;
      s_nxt.rp = s_r.rp - 1'b1;
    end
    if (bs.stb && bs.sop) begin
      s_nxt.hdr[0] = bs.data;
      s_nxt.idx = 8'h01;
      s_nxt.st = tsp_pkg::ST_HDR;
      s_nxt.arr = s_r.stc;
      s_nxt.descr_en = 1'b0;
      s_nxt.pcr_arm = 1'b0;
    end else if (bs.stb) begin
      unique case (s_r.st)
        tsp_pkg::ST_IDLE: begin
          s_nxt.st = tsp_pkg::ST_IDLE;
        end
        tsp_pkg::ST_HDR: begin
          s_nxt.hdr[s_r.idx[1:0]] = bs.data;
          s_nxt.idx = s_r.idx + 1'b1;
          if (s_r.idx == 8'(tsp_pkg::HDR_LEN - 1)) begin
            s_nxt.st = tsp_pkg::ST_BODY;
            s_nxt.slot = m[SW-1:0];
            s_nxt.cls = m[SW] ? tsp_pkg::tsp_class_t'(s_r.tcls[m[SW-1:0]])
                              : tsp_pkg::CLS_DISCARD;
            if (m[SW]) begin
              s_nxt.rp = 3'(tsp_pkg::HDR_LEN);
              s_nxt.descr_en = s_r.tdsc[m[SW-1:0]] &&
                               bs.data[7:6] != 2'h0;
              s_nxt.descr_key = s_r.key[m[SW-1:0]];
              if (bs.data[tsp_pkg::BIT_PAYLOAD]) begin
                s_nxt.cc[m[SW-1:0]] = cn;
                s_nxt.ccv[m[SW-1:0]] = 1'b1;
                if (s_r.ccv[m[SW-1:0]] && cn != cl &&
                    cn != cl + 1'b1) begin
                  s_nxt.lost = 1'b1;
                  s_nxt.lost_pid = p;
                end
              end
            end
          end
        end
        tsp_pkg::ST_BODY: begin
          if (s_r.cls != tsp_pkg::CLS_DISCARD) begin
            s_nxt.dma_valid = 1'b1;
            s_nxt.dma_data = bs.data;
          end
          if (s_r.idx == 8'(tsp_pkg::IDX_ALEN)) begin
            s_nxt.pcr_arm = s_r.hdr[3][tsp_pkg::BIT_ADAPT] &&
                            bs.data != 8'h00;
          end
          if (s_r.idx == 8'(tsp_pkg::IDX_PCR) && s_r.pcr_arm &&
              bs.data[tsp_pkg::BIT_PCR]) begin
            s_nxt.pcr_stamp = s_r.arr;
            s_nxt.pcr_valid = 1'b1;
          end
          s_nxt.idx = s_r.idx + 1'b1;
          if (s_r.idx == 8'(tsp_pkg::PKT_LEN - 1)) begin
            s_nxt.st = tsp_pkg::ST_IDLE;
            s_nxt.descr_en = 1'b0;
            if (s_r.cls != tsp_pkg::CLS_DISCARD) begin
              s_nxt.dma_eop = 1'b1;
              s_nxt.irq = 1'b1;
            end
          end
        end
        default: begin
          s_nxt.st = tsp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dma_valid = s_r.dma_valid;
  assign dma_data = s_r.dma_data;
  assign dma_sop = s_r.dma_sop;
  assign dma_eop = s_r.dma_eop;
  assign dma_hdr = s_r.dma_hdr;
  assign dma_class = s_r.cls;
  assign descr_en = s_r.descr_en;
  assign descr_key = s_r.descr_key;
  assign fast_irq_req = s_r.irq;
  assign pcr_stamp = s_r.pcr_stamp;
  assign pcr_valid = s_r.pcr_valid;
  assign lost = s_r.lost;
  assign lost_pid = s_r.lost_pid;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  logic m_hit_chk;
  assign m_hit_chk = f_match({s_r.hdr[1][4:0], s_r.hdr[2]}, s_r.pid,
                             s_r.tcls) >> SW != '0;

  sequence seq_hdr_burst;
    (s_r.dma_valid && s_r.dma_hdr) [*4];
  endsequence

  a_hdr_replay: assert property (
    s_r.dma_sop |-> seq_hdr_burst ##1 !s_r.dma_hdr)
    else $error("header bytes not marked as a burst of four");
  a_irq_on_end: assert property (
    s_r.dma_eop |-> s_r.irq && s_r.idx == 8'(tsp_pkg::PKT_LEN))
    else $error("interrupt missing at end of kept packet");
  a_irq_held: assert property (
    s_r.irq && !fiq_ack |=> s_r.irq)
    else $error("interrupt dropped before acknowledge");
  a_discard_quiet: assert property (
    s_r.dma_valid && !s_r.dma_hdr |-> s_r.cls != tsp_pkg::CLS_DISCARD)
    else $error("discarded packet reached the transfer port");
  a_descr_scope: assert property (
    s_r.descr_en |-> s_r.st == tsp_pkg::ST_BODY)
    else $error("descrambler enabled outside a packet");
  a_pcr_latch: assert property (
    s_r.pcr_valid |-> s_r.pcr_stamp == s_r.arr &&
      s_r.idx == 8'(tsp_pkg::IDX_PCR + 1))
    else $error("clock stamp not the arrival time");
  a_lost_point: assert property (
    s_r.lost |-> s_r.st == tsp_pkg::ST_BODY &&
      s_r.idx == 8'(tsp_pkg::HDR_LEN))
    else $error("loss flagged away from header decision");
  a_lost_cc: assert property (
    bs.stb && !bs.sop && s_r.st == tsp_pkg::ST_HDR &&
      s_r.idx == 8'(tsp_pkg::HDR_LEN - 1) && !m_hit_chk |=> !s_r.lost)
    else $error("loss flagged for an unmatched identifier");
endmodule

// >>> verilog/tsp_parser_fix.sv
// Spare file: holds no logic.

// >>> verif/tsp_stream_src.sv
// Upstream stream source: sends one whole packet per call on the byte link.
// Assumes the caller hands over 188 bytes; the link clock idles low.
`timescale 1ns/10ps
module tsp_stream_src (
  output logic ts_clk,
  output logic ts_valid,
  output logic ts_start,
  output logic [7:0] ts_data
);
  initial begin
    ts_clk = 1'b0;
    ts_valid = 1'b0;
    ts_start = 1'b0;
    ts_data = 8'h00;
  end

  // ----------------------------------------------------------------
  // Packet sender
  // ----------------------------------------------------------------
  // Lines change at least 80 ns after each rise, so they hold past the sampler
  task automatic send(input logic [7:0] p [188], input int pause);
    for (int i = 0; i < 188; i++) begin
      ts_valid = 1'b1;
      ts_start = (i == 0);
      ts_data = p[i];
      #80 ts_clk = 1'b1;
      #80 ts_clk = 1'b0;
      // Slow source: clock stands still in mid-frame
      if (pause != 0 && i == 93) #(pause);
    end
    // Released lines must not keep showing the last byte
    ts_valid = 1'b0;
    ts_start = 1'b0;
    ts_data = ~ts_data;
  endtask
endmodule

// >>> verif/test_transport_packet_parser.sv
// Self-checking bench for the transport packet parser core.
// Assumes the stream source model drives the link pins.
`timescale 1ns/10ps
module test_transport_packet_parser;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ts_clk, ts_valid, ts_start;
  logic [7:0] ts_data;
  logic tbl_wr = 1'b0;
  logic [2:0] tbl_idx = 3'h0;
  logic [12:0] tbl_pid = 13'h0000;
  logic [1:0] tbl_class = 2'h0;
  logic tbl_descr = 1'b0;
  logic key_wr = 1'b0;
  logic [2:0] key_idx = 3'h0;
  logic [63:0] key_data = 64'h0;
  logic fiq_ack = 1'b0;
  logic [7:0] dac_level = 8'h00;
  logic dma_valid, dma_sop, dma_eop, dma_hdr, descr_en, fast_irq_req;
  logic pcr_valid, lost, dac_out, den_q, dac_q;
  logic [7:0] dma_data;
  logic [1:0] dma_class, cls_q;
  logic [63:0] descr_key, key_q;
  logic [41:0] pcr_stamp, stamp_q;
  logic [12:0] lost_pid, lpid_q;
  logic [7:0] pkt [188];
  logic [7:0] got [188];
  int failures = 0;
  int n_tests = 0;
  int n_b, n_sop, n_eop, n_hdr, n_pcr, n_lost, n_dac, s0;
  int cyc = 0;
  int cyc_rel = 0;
  localparam int LIMIT = 60000;

  tsp_parser #(.SLOTS(8), .DAC_DIV(4)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .ts_clk(ts_clk),
    .ts_valid(ts_valid), .ts_start(ts_start), .ts_data(ts_data),
    .tbl_wr(tbl_wr), .tbl_idx(tbl_idx), .tbl_pid(tbl_pid),
    .tbl_class(tbl_class), .tbl_descr(tbl_descr), .key_wr(key_wr),
    .key_idx(key_idx), .key_data(key_data), .fiq_ack(fiq_ack),
    .dac_level(dac_level), .dma_valid(dma_valid), .dma_data(dma_data),
    .dma_sop(dma_sop), .dma_eop(dma_eop), .dma_hdr(dma_hdr),
    .dma_class(dma_class), .descr_en(descr_en), .descr_key(descr_key),
    .fast_irq_req(fast_irq_req), .pcr_stamp(pcr_stamp),
    .pcr_valid(pcr_valid), .lost(lost), .lost_pid(lost_pid),
    .dac_out(dac_out)
  );

  tsp_stream_src src (
    .ts_clk(ts_clk), .ts_valid(ts_valid), .ts_start(ts_start),
    .ts_data(ts_data)
  );

  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Output monitor
  // ----------------------------------------------------------------
  // Sampled on the falling edge, where registered outputs have settled
  always @(negedge sys_clk) begin
    cyc++;
    if (dma_valid === 1'b1) begin
      if (n_b < 188) got[n_b] = dma_data;
      n_b++;
      if (dma_hdr === 1'b1) n_hdr++;
      if (dma_eop === 1'b1) n_eop++;
      if (dma_sop === 1'b1) begin
        n_sop++;
        cls_q = dma_class;
        den_q = descr_en;
        key_q = descr_key;
      end
    end
    if (pcr_valid === 1'b1) begin
      n_pcr++;
      stamp_q = pcr_stamp;
    end
    if (lost === 1'b1) begin
      n_lost++;
      lpid_q = lost_pid;
    end
    if (dac_out === 1'b1 && dac_q !== 1'b1) n_dac++;
    dac_q = dac_out;
    if (cyc == LIMIT) begin
      failures++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got_v, input logic [63:0] exp_v);
    n_tests++;
    if (got_v !== exp_v) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got_v,
               exp_v);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic set_slot(input logic [2:0] i, input logic [12:0] pid,
                          input logic [1:0] cls, input logic d);
    tbl_idx = i;
    tbl_pid = pid;
    tbl_class = cls;
    tbl_descr = d;
    tbl_wr = 1'b1;
    tick(1);
    tbl_wr = 1'b0;
    tick(1);
  endtask

  task automatic ack();
    fiq_ack = 1'b1;
    tick(1);
    fiq_ack = 1'b0;
    tick(1);
  endtask

  task automatic run_pkt(input logic [12:0] pid, input logic [1:0] sc,
                         input logic [3:0] cc, input logic pcr,
                         input int pause);
    pkt[0] = 8'h47;
    pkt[1] = {3'h0, pid[12:8]};
    pkt[2] = pid[7:0];
    pkt[3] = {sc, pcr, 1'b1, cc};
    for (int i = 4; i < 188; i++) pkt[i] = i[7:0] ^ 8'h5A;
    if (pcr) begin
      pkt[4] = 8'h07;
      pkt[5] = 8'h10;
    end
    {n_b, n_sop, n_eop, n_hdr, n_pcr, n_lost} = '0;
    s0 = cyc - cyc_rel;
    src.send(pkt, pause);
    tick(20);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({dma_valid, fast_irq_req, pcr_valid, lost, dac_out}, 64'h0);
    $display("reset test done");
  endtask

  task automatic t_host();
    set_slot(3'h0, 13'h0100, 2'h1, 1'b1);
    key_idx = 3'h0;
    key_data = 64'hA5C3_0F1E_2D3C_4B5A;
    key_wr = 1'b1;
    tick(1);
    key_wr = 1'b0;
    run_pkt(13'h0100, 2'h2, 4'h0, 1'b1, 0);
    chk(n_b, 188);
    for (int i = 0; i < 188; i++) chk(got[i], pkt[i]);
    chk({n_sop[3:0], n_eop[3:0], n_hdr[3:0]}, 12'h114);
    chk(cls_q, 2'h1);
    chk(den_q, 1'b1);
    chk(key_q, 64'hA5C3_0F1E_2D3C_4B5A);
    chk(fast_irq_req, 1'b1);
    chk(n_pcr, 1);
    chk(stamp_q >= s0 && stamp_q <= s0 + 40, 1'b1);
    ack();
    chk(fast_irq_req, 1'b0);
    $display("host packet test done");
  endtask

  task automatic t_data();
    set_slot(3'h1, 13'h0200, 2'h2, 1'b0);
    run_pkt(13'h0200, 2'h2, 4'h0, 1'b0, 700);
    chk(n_b, 188);
    chk(cls_q, 2'h2);
    chk(den_q, 1'b0);
    chk(n_pcr, 0);
    chk(fast_irq_req, 1'b1);
    ack();
    $display("data packet test done");
  endtask

  task automatic t_discard();
    run_pkt(13'h0333, 2'h0, 4'h0, 1'b0, 0);
    chk(n_b, 0);
    chk(fast_irq_req, 1'b0);
    $display("discard test done");
  endtask

  task automatic t_loss();
    logic [3:0] ccs [3] = '{4'h1, 4'h1, 4'h3};
    int exp_l [3] = '{0, 0, 1};
    for (int k = 0; k < 3; k++) begin
      run_pkt(13'h0200, 2'h0, ccs[k], 1'b0, 0);
      chk(n_lost, exp_l[k]);
      ack();
    end
    chk(lpid_q, 13'h0200);
    $display("loss test done");
  endtask

  task automatic t_dac();
    // Centre level first: a carry on every second update
    dac_level = 8'h80;
    tick(8);
    n_dac = 0;
    tick(256);
    chk(n_dac >= 31 && n_dac <= 33, 1'b1);
    dac_level = 8'h40;
    tick(8);
    n_dac = 0;
    tick(1024);
    chk(n_dac >= 62 && n_dac <= 66, 1'b1);
    $display("dac test done");
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    cyc_rel = cyc;
    tick(1);
    t_reset();
    t_host();
    t_data();
    t_discard();
    t_loss();
    t_dac();
    test_done();
  end
endmodule
